//--- dds_pkg.sv
// Constants, encodings and carrier types of the dual-channel sine engine.
// Assumes one 100 MHz system clock and a synchronous active-low reset.
package dds_pkg;

    // ==========================================================
    // Widths and sizes
    localparam int PHASE_W = 20;
    localparam int SAMPLE_W = 16;
    localparam int FAST_W = 12;
    localparam int ADDR_W = 10;
    localparam int MEM_DEPTH = 1024;
    localparam int QUEUE_DEPTH = 4;
    localparam int QPTR_W = 2;
    localparam int FREQ_W = 17;
    localparam int AMPL_W = 14;
    localparam int LOG2_W = 5;
    localparam int DIGITS_W = 12;
    localparam int RANGE_W = 2;

    // ==========================================================
    // Limits on requests (frequency in Hz, amplitude in 10 mV steps)
    localparam logic [FREQ_W-1:0] FREQ_MAX = 17'h0C350;
    localparam logic [FREQ_W-1:0] FREQ_MIN = 17'h00002;
    localparam logic [FREQ_W-1:0] BAND_EDGE = 17'h01388;
    localparam logic [AMPL_W-1:0] AMPL_MAX = 14'h2710;

    // ==========================================================
    // Sample-count and strobe-rate selection
    localparam logic [LOG2_W-1:0] LOG2_MIN = 5'h06;
    localparam logic [LOG2_W-1:0] LOG2_MAX_LOW = 5'h11;
    localparam logic [LOG2_W-1:0] LOG2_MAX_HIGH = 5'h0A;
    localparam logic [39:0] LOW_RATE_MIN = 40'h0000030D40;
    localparam logic [39:0] HIGH_RATE_MIN = 40'h00001E8480;
    localparam logic [39:0] LOW_DIGIT_DIV = 40'h0000000064;
    localparam logic [39:0] HIGH_DIGIT_DIV = 40'h00000003E8;
    localparam logic [RANGE_W-1:0] RANGE_X100K = 2'h0;
    localparam logic [RANGE_W-1:0] RANGE_LSB = 2'h1;

    // ==========================================================
    // Timing
    localparam int CLOCK_MHZ = 100;
    localparam int SINE_TIME_NS = 400;
    localparam int SINE_CYCLES = SINE_TIME_NS * CLOCK_MHZ / 1000;
    localparam int LOW_STROBE_MIN_NS = 2500;
    localparam int HIGH_STROBE_MIN_NS = 250;

    // ==========================================================
    // Sine table: quarter wave, 16 segments
    localparam int SEG_IDX_W = 5;
    localparam int FRAC_W = 14;
    localparam logic [18:0] QUARTER_TURN = 19'h40000;
    localparam logic [ADDR_W-1:0] FILL_LAST = 10'h3FF;

    // ==========================================================
    // Types
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_TAKE  = 6'h02,
        ST_CALC0 = 6'h04,
        ST_CALC1 = 6'h08,
        ST_WRITE = 6'h10,
        ST_WAIT  = 6'h20
    } gen_state_type;

    typedef struct packed {
        logic [FREQ_W-1:0] freq;
        logic [AMPL_W-1:0] ampl;
        logic [PHASE_W-1:0] phase0;
        logic [PHASE_W-1:0] phase1;
    } cmd_type;

    typedef struct packed {
        logic high_freq;
        logic low_freq;
        logic high_volt;
        logic queue_full;
    } err_type;

    typedef struct packed {
        logic [RANGE_W-1:0] range;
        logic [DIGITS_W-1:0] digits;
    } synth_type;

endpackage : dds_pkg

//--- dds_sine_engine.sv
// Dual-channel direct digital sine engine with command queue and checks.
// Assumes commands come from logic on clock_in and strobe_in is an
// asynchronous pin driven by the external rate synthesizer.
`timescale 1ns/1ps
module dds_sine_engine (
    input wire logic clock_in,                          // 100 MHz clock
    input wire logic rst_n_in,                          // Sync reset
    input wire logic cmd_valid_in,                      // Command strobe
    input wire dds_pkg::cmd_type cmd_in,                // Command word
    input wire logic strobe_in,                         // Synth strobe pin
    output logic [dds_pkg::SAMPLE_W-1:0] dac16_ch0_out, // 16-bit ch 0
    output logic [dds_pkg::SAMPLE_W-1:0] dac16_ch1_out, // 16-bit ch 1
    output logic [dds_pkg::FAST_W-1:0] dac12_ch0_out,   // 12-bit ch 0
    output logic [dds_pkg::FAST_W-1:0] dac12_ch1_out,   // 12-bit ch 1
    output logic dac_fast_out,                          // 1: 12-bit path
    output dds_pkg::synth_type synth_out,               // Strobe setting
    output dds_pkg::err_type err_out,                   // Error flags
    output logic [dds_pkg::LOG2_W-1:0] samples_log2_out,// Log2 of count
    output logic running_out                            // Waveform active
);

    // ==========================================================
    // Functions
    function automatic logic [15:0] sine_point(input logic [4:0] idx);
        logic [15:0] value;
        value = 16'h0000;
        unique case (idx)
            5'h00: value = 16'h0000;
            5'h01: value = 16'h0C8C;
            5'h02: value = 16'h18F9;
            5'h03: value = 16'h2528;
            5'h04: value = 16'h30FB;
            5'h05: value = 16'h3C56;
            5'h06: value = 16'h471C;
            5'h07: value = 16'h5133;
            5'h08: value = 16'h5A82;
            5'h09: value = 16'h62F1;
            5'h0A: value = 16'h6A6D;
            5'h0B: value = 16'h70E2;
            5'h0C: value = 16'h7641;
            5'h0D: value = 16'h7A7C;
            5'h0E: value = 16'h7D89;
            5'h0F: value = 16'h7F61;
            default: value = 16'h7FFF;
        endcase
        return value;
    endfunction : sine_point

    // Single-cycle table walk keeps the result far inside the 400 ns budget
    function automatic logic [15:0] phase_to_sine(
        input logic [dds_pkg::PHASE_W-1:0] phase
    );
        logic [18:0] folded;
        logic [4:0] idx;
        logic [4:0] idx_next;
        logic [15:0] lo;
        logic [15:0] hi;
        logic [31:0] step;
        logic [15:0] mag;
        folded = phase[18] ? (dds_pkg::QUARTER_TURN - {1'b0, phase[17:0]})
                           : {1'b0, phase[17:0]};
        idx = folded[18:14];
        idx_next = (idx == 5'h10) ? idx : 5'(idx + 5'h01);
        lo = sine_point(idx);
        hi = sine_point(idx_next);
        step = 32'(hi - lo) * {18'h00000, folded[13:0]};
        mag = 16'(lo + 16'(step >> dds_pkg::FRAC_W));
        return phase[19] ? 16'(~mag + 16'h0001) : mag;
    endfunction : phase_to_sine

    // Smallest power of two that lifts the strobe rate into its band
    function automatic logic [dds_pkg::LOG2_W-1:0] pick_log2(
        input logic [dds_pkg::FREQ_W-1:0] freq,
        input logic high
    );
        logic [dds_pkg::LOG2_W-1:0] k;
        logic [dds_pkg::LOG2_W-1:0] top;
        logic [39:0] floor_rate;
        logic found;
        k = high ? dds_pkg::LOG2_MAX_HIGH : dds_pkg::LOG2_MAX_LOW;
        top = k;
        floor_rate = high ? dds_pkg::HIGH_RATE_MIN : dds_pkg::LOW_RATE_MIN;
        found = 1'b0;
        for (int i = 6; i <= 17; i++) begin
            if (!found && 5'(i) <= top &&
                ({23'h000000, freq} << i) >= floor_rate) begin
                k = 5'(i);
                found = 1'b1;
            end
        end
        return k;
    endfunction : pick_log2

    // ==========================================================
    // Strobe pin synchroniser and edge detect
    logic strobe_meta;
    logic strobe_sync;
    logic strobe_prev;
    logic strobe_edge;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            strobe_meta <= 1'b0;
            strobe_sync <= 1'b0;
            strobe_prev <= 1'b0;
        end else begin
            strobe_meta <= strobe_in;
            strobe_sync <= strobe_meta;
            strobe_prev <= strobe_sync;
        end
    end

    assign strobe_edge = strobe_sync && !strobe_prev;

    // ==========================================================
    // Command queue
    dds_pkg::cmd_type queue_mem [dds_pkg::QUEUE_DEPTH];
    logic [dds_pkg::QPTR_W-1:0] q_wr;
    logic [dds_pkg::QPTR_W-1:0] q_rd;
    logic [dds_pkg::QPTR_W:0] q_count;
    logic queue_full;
    logic [dds_pkg::QPTR_W-1:0] next_q_wr;
    logic [dds_pkg::QPTR_W-1:0] next_q_rd;
    logic [dds_pkg::QPTR_W:0] next_q_count;
    logic next_queue_full;
    logic q_push;
    logic q_pop;
    dds_pkg::cmd_type q_head;

    assign q_head = queue_mem[q_rd];

    always_comb begin
        q_push = cmd_valid_in &&
                 (q_count != (dds_pkg::QPTR_W+1)'(dds_pkg::QUEUE_DEPTH) ||
                  q_pop);
        next_q_wr = q_push ? 2'(q_wr + 2'h1) : q_wr;
        next_q_rd = q_pop ? 2'(q_rd + 2'h1) : q_rd;
        next_q_count = 3'(q_count + {2'h0, q_push} - {2'h0, q_pop});
        next_queue_full = queue_full;
        if (cmd_valid_in && !q_push) begin
            next_queue_full = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            q_wr <= '0;
            q_rd <= '0;
            q_count <= '0;
            queue_full <= 1'b0;
        end else begin
            q_wr <= next_q_wr;
            q_rd <= next_q_rd;
            q_count <= next_q_count;
            queue_full <= next_queue_full;
        end
    end

    // Storage carries no reset; only pointers define what is valid
    always_ff @(posedge clock_in) begin
        if (q_push) begin
            queue_mem[q_wr] <= cmd_in;
        end
    end

    // ==========================================================
    // Sample banks
    logic [dds_pkg::SAMPLE_W-1:0] bank0 [dds_pkg::MEM_DEPTH];
    logic [dds_pkg::SAMPLE_W-1:0] bank1 [dds_pkg::MEM_DEPTH];
    logic mem_we;

    // ==========================================================
    // Generator state
    dds_pkg::gen_state_type state;
    dds_pkg::gen_state_type next_state;
    logic [dds_pkg::PHASE_W-1:0] acc0;
    logic [dds_pkg::PHASE_W-1:0] acc1;
    logic [dds_pkg::PHASE_W-1:0] init0;
    logic [dds_pkg::PHASE_W-1:0] init1;
    logic [dds_pkg::PHASE_W-1:0] phase_inc;
    logic [17:0] pt_last;
    logic [17:0] pt_cnt;
    logic [dds_pkg::ADDR_W-1:0] fill_cnt;
    logic [dds_pkg::ADDR_W-1:0] rd_addr;
    logic [dds_pkg::SAMPLE_W-1:0] sin0;
    logic [dds_pkg::SAMPLE_W-1:0] sin1;
    logic high_band;
    logic holding;
    logic running;
    logic [dds_pkg::LOG2_W-1:0] log2_n;
    dds_pkg::synth_type synth;
    logic err_hf;
    logic err_lf;
    logic err_hv;
    logic [dds_pkg::SAMPLE_W-1:0] dac16_0;
    logic [dds_pkg::SAMPLE_W-1:0] dac16_1;
    logic [dds_pkg::FAST_W-1:0] dac12_0;
    logic [dds_pkg::FAST_W-1:0] dac12_1;

    logic [dds_pkg::PHASE_W-1:0] next_acc0;
    logic [dds_pkg::PHASE_W-1:0] next_acc1;
    logic [dds_pkg::PHASE_W-1:0] next_init0;
    logic [dds_pkg::PHASE_W-1:0] next_init1;
    logic [dds_pkg::PHASE_W-1:0] next_phase_inc;
    logic [17:0] next_pt_last;
    logic [17:0] next_pt_cnt;
    logic [dds_pkg::ADDR_W-1:0] next_fill_cnt;
    logic [dds_pkg::ADDR_W-1:0] next_rd_addr;
    logic [dds_pkg::SAMPLE_W-1:0] next_sin0;
    logic [dds_pkg::SAMPLE_W-1:0] next_sin1;
    logic next_high_band;
    logic next_holding;
    logic next_running;
    logic [dds_pkg::LOG2_W-1:0] next_log2_n;
    dds_pkg::synth_type next_synth;
    logic next_err_hf;
    logic next_err_lf;
    logic next_err_hv;
    logic [dds_pkg::SAMPLE_W-1:0] next_dac16_0;
    logic [dds_pkg::SAMPLE_W-1:0] next_dac16_1;
    logic [dds_pkg::FAST_W-1:0] next_dac12_0;
    logic [dds_pkg::FAST_W-1:0] next_dac12_1;

    logic latch;
    logic bad_hf;
    logic bad_lf;
    logic bad_hv;
    logic take_high;
    logic [dds_pkg::LOG2_W-1:0] take_log2;
    logic [39:0] take_rate;

    always_comb begin
        next_state = state;
        next_acc0 = acc0;
        next_acc1 = acc1;
        next_init0 = init0;
        next_init1 = init1;
        next_phase_inc = phase_inc;
        next_pt_last = pt_last;
        next_pt_cnt = pt_cnt;
        next_fill_cnt = fill_cnt;
        next_rd_addr = rd_addr;
        next_sin0 = sin0;
        next_sin1 = sin1;
        next_high_band = high_band;
        next_holding = holding;
        next_running = running;
        next_log2_n = log2_n;
        next_synth = synth;
        next_err_hf = err_hf;
        next_err_lf = err_lf;
        next_err_hv = err_hv;
        next_dac16_0 = dac16_0;
        next_dac16_1 = dac16_1;
        next_dac12_0 = dac12_0;
        next_dac12_1 = dac12_1;
        q_pop = 1'b0;
        mem_we = 1'b0;

        bad_hf = q_head.freq > dds_pkg::FREQ_MAX;
        bad_lf = q_head.freq < dds_pkg::FREQ_MIN;
        bad_hv = q_head.ampl > dds_pkg::AMPL_MAX;
        take_high = q_head.freq > dds_pkg::BAND_EDGE;
        take_log2 = pick_log2(q_head.freq, take_high);
        take_rate = {23'h000000, q_head.freq} << take_log2;

        // Converter registers change only on a strobe, never in between
        latch = strobe_edge && running && (state == dds_pkg::ST_WAIT);
        if (latch) begin
            if (high_band) begin
                next_dac12_0 = bank0[rd_addr][15:4];
                next_dac12_1 = bank1[rd_addr][15:4];
            end else begin
                next_dac16_0 = bank0[rd_addr];
                next_dac16_1 = bank1[rd_addr];
            end
            next_rd_addr = 10'(rd_addr + 10'h001);
        end

        unique case (state)
            dds_pkg::ST_IDLE: begin
                if (q_count != '0) begin
                    next_state = dds_pkg::ST_TAKE;
                end
            end
            dds_pkg::ST_TAKE: begin
                q_pop = 1'b1;
                next_err_hf = bad_hf;
                next_err_lf = bad_lf;
                next_err_hv = bad_hv;
                if (bad_hf || bad_lf || bad_hv) begin
                    // Rejected: the previous waveform carries on
                    if (!running) begin
                        next_state = dds_pkg::ST_IDLE;
                    end else if (holding) begin
                        next_state = dds_pkg::ST_WAIT;
                    end else begin
                        next_state = dds_pkg::ST_CALC0;
                    end
                end else begin
                    next_init0 = q_head.phase0;
                    next_init1 = q_head.phase1;
                    next_acc0 = q_head.phase0;
                    next_acc1 = q_head.phase1;
                    next_phase_inc = 20'h80000 >> (take_log2 - 5'h01);
                    next_pt_last = 18'((18'h00001 << take_log2) - 18'h00001);
                    next_log2_n = take_log2;
                    next_pt_cnt = '0;
                    next_fill_cnt = '0;
                    next_rd_addr = '0;
                    next_high_band = take_high;
                    next_holding = 1'b0;
                    next_running = 1'b1;
                    next_synth.range = dds_pkg::RANGE_X100K;
                    if (take_high) begin
                        // Same digits on the lower range: a tenth of the rate
                        next_synth.digits =
                            12'(take_rate / dds_pkg::HIGH_DIGIT_DIV);
                    end else begin
                        next_synth.digits =
                            12'(take_rate / dds_pkg::LOW_DIGIT_DIV);
                    end
                    next_state = dds_pkg::ST_CALC0;
                end
            end
            dds_pkg::ST_CALC0: begin
                next_sin0 = phase_to_sine(acc0);
                next_state = dds_pkg::ST_CALC1;
            end
            dds_pkg::ST_CALC1: begin
                next_sin1 = phase_to_sine(acc1);
                next_state = dds_pkg::ST_WRITE;
            end
            dds_pkg::ST_WRITE: begin
                mem_we = 1'b1;
                if (pt_cnt == pt_last) begin
                    next_acc0 = init0;
                    next_acc1 = init1;
                    next_pt_cnt = '0;
                end else begin
                    next_acc0 = 20'(acc0 + phase_inc);
                    next_acc1 = 20'(acc1 + phase_inc);
                    next_pt_cnt = 18'(pt_cnt + 18'h00001);
                end
                next_state = dds_pkg::ST_WAIT;
                if (high_band) begin
                    next_fill_cnt = 10'(fill_cnt + 10'h001);
                    if (fill_cnt == dds_pkg::FILL_LAST) begin
                        next_holding = 1'b1;
                        next_synth.range =
                            synth.range ^ dds_pkg::RANGE_LSB;
                    end
                end
            end
            dds_pkg::ST_WAIT: begin
                if (holding) begin
                    // Idle loop: banks replay, nothing is recomputed
                    if (q_count != '0) begin
                        next_state = dds_pkg::ST_TAKE;
                    end
                end else if (strobe_edge) begin
                    if (!high_band && pt_cnt == '0 && q_count != '0) begin
                        next_state = dds_pkg::ST_TAKE;
                    end else begin
                        next_state = dds_pkg::ST_CALC0;
                    end
                end
            end
            default: begin
                next_state = dds_pkg::ST_IDLE;
            end
        endcase
    end

    // Banks are written before the strobe that reads that address
    always_ff @(posedge clock_in) begin
        if (mem_we) begin
            bank0[rd_addr] <= sin0;
            bank1[rd_addr] <= sin1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state <= dds_pkg::ST_IDLE;
            acc0 <= '0;
            acc1 <= '0;
            init0 <= '0;
            init1 <= '0;
            phase_inc <= '0;
            pt_last <= '0;
            pt_cnt <= '0;
            fill_cnt <= '0;
            rd_addr <= '0;
            sin0 <= '0;
            sin1 <= '0;
            high_band <= 1'b0;
            holding <= 1'b0;
            running <= 1'b0;
            log2_n <= dds_pkg::LOG2_MIN;
            synth <= '0;
            err_hf <= 1'b0;
            err_lf <= 1'b0;
            err_hv <= 1'b0;
            dac16_0 <= '0;
            dac16_1 <= '0;
            dac12_0 <= '0;
            dac12_1 <= '0;
        end else begin
            state <= next_state;
            acc0 <= next_acc0;
            acc1 <= next_acc1;
            init0 <= next_init0;
            init1 <= next_init1;
            phase_inc <= next_phase_inc;
            pt_last <= next_pt_last;
            pt_cnt <= next_pt_cnt;
            fill_cnt <= next_fill_cnt;
            rd_addr <= next_rd_addr;
            sin0 <= next_sin0;
            sin1 <= next_sin1;
            high_band <= next_high_band;
            holding <= next_holding;
            running <= next_running;
            log2_n <= next_log2_n;
            synth <= next_synth;
            err_hf <= next_err_hf;
            err_lf <= next_err_lf;
            err_hv <= next_err_hv;
            dac16_0 <= next_dac16_0;
            dac16_1 <= next_dac16_1;
            dac12_0 <= next_dac12_0;
            dac12_1 <= next_dac12_1;
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops
    assign dac16_ch0_out = dac16_0;
    assign dac16_ch1_out = dac16_1;
    assign dac12_ch0_out = dac12_0;
    assign dac12_ch1_out = dac12_1;
    assign dac_fast_out = high_band;
    assign synth_out = synth;
    assign err_out = '{high_freq: err_hf, low_freq: err_lf,
                       high_volt: err_hv, queue_full: queue_full};
    assign samples_log2_out = log2_n;
    assign running_out = running;

endmodule : dds_sine_engine

//--- dds_sine_engine_properties.sv
// Port checker of the sine engine.
// Assumes binding to every dds_sine_engine instance.
`timescale 1ns/1ps
module dds_sine_engine_properties (
    input wire logic clock_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic strobe_in, // Strobe pin
    input wire logic [15:0] dac16_ch0_out, // Sample
    input wire logic dac_fast_out, // Path
    input wire dds_pkg::synth_type synth_out, // Rate
    input wire dds_pkg::err_type err_out, // Errors
    input wire logic [4:0] samples_log2_out, // Count
    input wire logic running_out // Active
);
    // ==========================================
    // Properties
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    chk_queue_sticky:
        assert property (err_out.queue_full |=> err_out.queue_full)
        else $error("queue flag dropped");
    chk_err_single:
        assert property (!(err_out.high_freq && err_out.low_freq))
        else $error("both frequency errors");
    chk_fast_range:
        assert property (synth_out.range == 2'h1 |-> dac_fast_out)
        else $error("fast range in low band");
    chk_high_count:
        assert property (dac_fast_out |-> samples_log2_out <= 5'h0A)
        else $error("high band count too big");
    chk_low_count:
        assert property (running_out |-> samples_log2_out inside {[6:17]})
        else $error("sample count out of range");
    chk_rate_digits:
        assert property (running_out |-> synth_out.digits inside {[2000:4000]})
        else $error("strobe rate out of band");
    // Strobe is seen 3 or 4 edges late through the synchronizer
    chk_dac_hold:
        assert property ($changed(dac16_ch0_out) |->
            $past(strobe_in, 3) || $past(strobe_in, 4))
        else $error("sample changed without strobe");
    chk_idle_quiet:
        assert property (!running_out |=> $stable(dac16_ch0_out))
        else $error("sample changed while idle");
endmodule : dds_sine_engine_properties
bind dds_sine_engine dds_sine_engine_properties dds_sine_engine_properties_inst (
    .clock_in, .rst_n_in, .strobe_in, .dac16_ch0_out, .dac_fast_out,
    .synth_out, .err_out, .samples_log2_out, .running_out);

//--- dds_strobe_model.sv
// Rate synthesizer model: strobe rate follows the engine's setting.
// Assumes a 100 MHz clock_in; strobe stands low while idle.
`timescale 1ns/1ps
module dds_strobe_model (
    input wire logic clock_in, // Clock
    input wire logic run_in, // Engine active
    input wire dds_pkg::synth_type synth_in, // Rate setting
    output logic strobe_out = 1'b0 // Strobe pin
);
    int count = 0;
    int period;
    // ==========================================
    // Range 0 steps 100 Hz, range 1 steps 1 kHz
    always @(posedge clock_in) begin
        period = (synth_in.digits == 12'h000) ? 1000 : 100000000 /
            (synth_in.digits * (synth_in.range[0] ? 1000 : 100));
        count <= (!run_in || count >= period) ? 0 : count + 1;
        strobe_out <= run_in && count < 3;
    end
endmodule : dds_strobe_model

//--- dual_channel_dds_sine_generator_bench.sv
// Self-checking bench of the dual-channel sine engine.
// Assumes the strobe model stands in for the synthesizer.
`timescale 1ns/1ps
module dual_channel_dds_sine_generator_bench;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cmd_valid_in = 1'b0;
    dds_pkg::cmd_type cmd_in = '0;
    logic strobe_in, fast, running;
    logic [15:0] d16a, d16b;
    logic [11:0] d12a, d12b;
    dds_pkg::synth_type synth;
    dds_pkg::err_type err;
    logic [4:0] log2;
    int err_total = 0;
    int checked = 0;
    int f;
    int bad_f[3] = '{50001, 1, 100};
    int bad_a[3] = '{100, 100, 10001};
    dds_sine_engine dds_sine_engine_inst (.clock_in(clock_in),
        .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .strobe_in(strobe_in), .dac16_ch0_out(d16a), .dac16_ch1_out(d16b),
        .dac12_ch0_out(d12a), .dac12_ch1_out(d12b), .dac_fast_out(fast),
        .synth_out(synth), .err_out(err), .samples_log2_out(log2),
        .running_out(running));
    dds_strobe_model dds_strobe_model_inst (.clock_in(clock_in),
        .run_in(running), .synth_in(synth), .strobe_out(strobe_in));
    // ==========================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    // One-cycle valid pulse per call; returns on the edge that takes it
    task automatic send(input int fr, input int am);
        @(posedge clock_in);
        cmd_valid_in <= 1'b1;
        cmd_in <= {fr[16:0], am[13:0], 20'h40000, 20'hC0000};
        @(posedge clock_in);
        cmd_valid_in <= 1'b0;
    endtask : send
    function automatic logic [17:0] expect_cfg(input int fr);
        int k = 6;
        int lo = (fr > 5000) ? 2000000 : 200000;
        while ((fr << k) < lo) k++;
        return {fr > 5000, k[4:0],
            12'((fr << k) / ((fr > 5000) ? 1000 : 100))};
    endfunction : expect_cfg
    task automatic stop_test();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    // ==========================================
    // Sequence
    initial forever #5 clock_in = ~clock_in;
    initial begin
        #1000000;
        err_total++;
        stop_test();
    end
    initial begin
        f = $urandom(72);
        repeat (6) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        #1 check({err, log2, running}, {4'h0, 5'h06, 1'b0});
        for (int i = 0; i < 3; i++) begin
            send(bad_f[i], bad_a[i]);
            repeat (3) @(posedge clock_in);
            #1 check(err, 4'h8 >> i);
        end
        f = 2500 + $urandom % 2501;
        send(f, $urandom % 10001);
        repeat (3) @(posedge clock_in);
        #1 check({running, fast, log2, synth.digits, err},
            {1'b1, expect_cfg(f), 4'h0});
        for (int n = 0; n < 2000 && d16a === 16'h0000; n++)
            @(posedge clock_in);
        #1 check(d16a[15:12], 4'h7);
        check(d16b[15:12], 4'h8);
        send(50000, 10000);
        for (int n = 0; n < 60000 && fast !== 1'b1; n++)
            @(posedge clock_in);
        #1 check({fast, log2, synth.digits, synth.range},
            {expect_cfg(50000), 2'h0});
        // Fill is still running, so nothing pops: the fifth push overflows
        repeat (5) send(4000, 0);
        repeat (3) @(posedge clock_in);
        #1 check(err.queue_full, 1'b1);
        for (int n = 0; n < 2000 && d12a === 12'h000; n++)
            @(posedge clock_in);
        #1 check(d12a, 12'h7FF);
        check(d12b, 12'h800);
        stop_test();
    end
endmodule : dual_channel_dds_sine_generator_bench
